// ### verilog/sfpi_defs.svh
`ifndef SFPI_DEFS_SVH
`define SFPI_DEFS_SVH

// ==========================================================================
// timing
`define SFPI_CLK_MHZ 125
`define SFPI_RESET_MIN_NS 1000
// least time, rounded up to whole system clock cycles
`define SFPI_RESET_CYC ((`SFPI_RESET_MIN_NS * `SFPI_CLK_MHZ + 999) / 1000)

// ==========================================================================
// lane output enable patterns, bit n drives lane n
`define SFPI_OE_NONE 4'h0
`define SFPI_OE_SINGLE 4'h2
`define SFPI_OE_DUAL 4'h3
`define SFPI_OE_QUAD 4'hf

// ==========================================================================
// pin positions in the system side synchroniser vector
`define SFPI_PIN_WP 0
`define SFPI_PIN_L3 1
`define SFPI_PIN_RST 2
`define SFPI_PIN_CS 3
`define SFPI_PIN_IDLE 4'hf

`endif

// ### verilog/sfpi_pkg.sv
package sfpi_pkg;

  // ========================================================================
  // lane width, one-hot; the code doubles as the bits moved per clock edge
  typedef enum logic [2:0] {
    SFPI_SINGLE = 3'h1,
    SFPI_DUAL = 3'h2,
    SFPI_QUAD = 3'h4
  } sfpi_width_t;

  typedef struct packed {
    logic protect_complement;
    logic small_unit_select;
    logic top_bottom_select;
    logic [2:0] block_guard;
  } sfpi_guard_t;

  typedef struct packed {
    logic quad_lane_enable;
    logic hold_reset_select;
    sfpi_width_t lane_width;
    logic status_lock_policy;
    sfpi_guard_t guard;
  } sfpi_cfg_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } sfpi_rx_t;

endpackage : sfpi_pkg

// ### verilog/sfpi_top.sv
`timescale 1ns/1ps
`include "sfpi_defs.svh"
module sfpi_top
  import sfpi_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] lane_in,
  output logic [3:0] lane_out,
  output logic [3:0] lane_oe,
  input wire logic reset_pin_n,
  input wire sfpi_cfg_t cfg,
  input wire logic tx_valid,
  input wire logic [7:0] tx_byte,
  output logic tx_ready,
  output sfpi_rx_t rx,
  output logic selected,
  output logic device_reset,
  output logic status_write_blocked,
  output logic region_locked,
  output sfpi_guard_t guard_active
);

  localparam logic [7:0] RST_LAST = 8'(`SFPI_RESET_CYC - 1);

  // ========================================================================
  // state types, one per clock domain and reset
  typedef struct packed {
    logic [3:0] pin_s1;
    logic [3:0] pin_s2;
    logic cs_d;
    logic rx_s1;
    logic rx_s2;
    logic rx_s3;
    logic ack_s1;
    logic ack_s2;
    logic tx_req;
    logic [7:0] tx_data;
    logic tx_ready;
    logic [7:0] rst_cnt;
    logic device_reset;
    logic armed;
    logic frame_ok;
    sfpi_rx_t rx;
    logic selected;
    logic status_write_blocked;
    logic region_locked;
    sfpi_guard_t guard;
  } sfpi_sys_t;

  // link side, survives deselect, cleared by system reset
  typedef struct packed {
    logic req_s1;
    logic req_s2;
    logic ack;
    logic [7:0] tx_word;
    logic qe_s1;
    logic qe_s2;
    logic hrs_s1;
    logic hrs_s2;
    sfpi_width_t w_s1;
    sfpi_width_t w_s2;
    logic [7:0] rx_word;
    logic rx_instr;
    logic rx_tgl;
  } sfpi_lcfg_t;

  // link side, rising edge, cleared by deselect
  typedef struct packed {
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic instr_done;
    logic tx_full;
    logic taken_seen;
  } sfpi_rise_t;

  // link side, falling edge, cleared by deselect
  typedef struct packed {
    logic [2:0] out_cnt;
    logic [7:0] tx_sh;
    logic [3:0] lane_out;
    logic taken_tgl;
    logic active;
  } sfpi_fall_t;

  sfpi_sys_t q;
  sfpi_sys_t next_q;
  sfpi_lcfg_t lc;
  sfpi_lcfg_t next_lc;
  sfpi_rise_t r;
  sfpi_rise_t next_r;
  sfpi_fall_t fl;
  sfpi_fall_t next_fl;
  logic hold_q;
  logic [3:0] oe_q;
  logic [3:0] next_oe;

  function automatic sfpi_width_t eff_width(input sfpi_width_t w, input logic qe);
    case (w)
      SFPI_DUAL: eff_width = SFPI_DUAL;
      SFPI_QUAD: eff_width = qe ? SFPI_QUAD : SFPI_SINGLE;
      default: eff_width = SFPI_SINGLE;
    endcase
  endfunction : eff_width

  // ========================================================================
  // link: pin function selection
  sfpi_width_t w_eff;
  sfpi_width_t rx_step;
  logic pause_en;
  logic pause_req;
  logic hold_set;
  logic float_now;
  logic [7:0] sh_in;
  logic [3:0] rx_sum;
  logic rx_done;
  logic tx_clr;
  logic tx_load;
  logic take;
  logic stream;
  logic [7:0] src;

  assign w_eff = eff_width(lc.w_s2, lc.qe_s2);
  // lane 3 is pause only with quad off and hold/reset select clear
  assign pause_en = !lc.qe_s2 && !lc.hrs_s2;
  assign pause_req = pause_en && !lane_in[3] && !cs_n;
  // clock already low: pause acts at once, otherwise at the next fall
  assign hold_set = pause_req && !sclk;
  assign float_now = cs_n || hold_set;

  // ========================================================================
  // link: rising edge capture
  always_comb begin
    next_r = r;
    next_lc = lc;
    // instruction byte is always single lane
    rx_step = r.instr_done ? w_eff : SFPI_SINGLE;
    case (rx_step)
      SFPI_DUAL: sh_in = {r.shift[5:0], lane_in[1], lane_in[0]};
      SFPI_QUAD: sh_in = {r.shift[3:0], lane_in[3:0]};
      default: sh_in = {r.shift[6:0], lane_in[0]};
    endcase
    rx_sum = {1'b0, r.bit_cnt} + {1'b0, rx_step};
    rx_done = rx_sum[3];
    next_lc.req_s1 = q.tx_req;
    next_lc.req_s2 = lc.req_s1;
    next_lc.qe_s1 = cfg.quad_lane_enable;
    next_lc.qe_s2 = lc.qe_s1;
    next_lc.hrs_s1 = cfg.hold_reset_select;
    next_lc.hrs_s2 = lc.hrs_s1;
    next_lc.w_s1 = cfg.lane_width;
    next_lc.w_s2 = lc.w_s1;
    // while paused the clock and input are ignored, state is kept
    if (!hold_q) begin
      next_r.bit_cnt = rx_sum[2:0];
      next_r.shift = sh_in;
      if (rx_done) begin
        next_r.instr_done = 1'b1;
        next_lc.rx_word = sh_in;
        next_lc.rx_instr = !r.instr_done;
        next_lc.rx_tgl = !lc.rx_tgl;
      end
    end
    // read byte slot: freed once the falling side took it
    tx_clr = r.tx_full && (fl.taken_tgl != r.taken_seen);
    if (tx_clr) begin
      next_r.taken_seen = fl.taken_tgl;
    end
    tx_load = (lc.req_s2 != lc.ack) && !(r.tx_full && !tx_clr);
    next_r.tx_full = (r.tx_full && !tx_clr) || tx_load;
    if (tx_load) begin
      next_lc.ack = lc.req_s2;
      next_lc.tx_word = q.tx_data;
    end
  end

  // deselect ends framing in any clock mode; reset gives a known state at power-up
  always_ff @(posedge sclk or posedge cs_n or posedge reset) begin
    if (cs_n || reset) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  always_ff @(posedge sclk or posedge reset) begin
    if (reset) begin
      lc <= '{w_s1: SFPI_SINGLE, w_s2: SFPI_SINGLE, default: '0};
    end else begin
      lc <= next_lc;
    end
  end

  // ========================================================================
  // link: falling edge drive
  always_comb begin
    next_fl = fl;
    take = (fl.out_cnt == 3'h0) && r.tx_full && (fl.taken_tgl == r.taken_seen);
    src = take ? lc.tx_word : fl.tx_sh;
    stream = take || (fl.out_cnt != 3'h0);
    if (!pause_req) begin
      next_fl.active = stream;
      if (stream) begin
        next_fl.out_cnt = fl.out_cnt + w_eff;
        if (take) begin
          next_fl.taken_tgl = !fl.taken_tgl;
        end
        case (w_eff)
          SFPI_DUAL: begin
            next_fl.lane_out = {2'b00, src[7], src[6]};
            next_fl.tx_sh = {src[5:0], 2'b00};
          end
          SFPI_QUAD: begin
            next_fl.lane_out = src[7:4];
            next_fl.tx_sh = {src[3:0], 4'h0};
          end
          default: begin
            next_fl.lane_out = {2'b00, src[7], 1'b0};
            next_fl.tx_sh = {src[6:0], 1'b0};
          end
        endcase
      end
    end
    next_oe = `SFPI_OE_NONE;
    if (!pause_req && next_fl.active) begin
      case (w_eff)
        SFPI_DUAL: next_oe = `SFPI_OE_DUAL;
        SFPI_QUAD: next_oe = `SFPI_OE_QUAD;
        default: next_oe = `SFPI_OE_SINGLE;
      endcase
    end
  end

  // a loaded but unsent read byte is dropped at deselect
  always_ff @(negedge sclk or posedge cs_n or posedge reset) begin
    if (cs_n || reset) begin
      fl <= '0;
    end else begin
      fl <= next_fl;
    end
  end

  // pin release waits for a falling edge, deselect or reset releases at once; a pin cannot both set and clear
  always_ff @(negedge sclk or posedge hold_set or posedge cs_n or posedge reset) begin
    if (cs_n || reset) begin
      hold_q <= 1'b0;
    end else if (hold_set) begin
      hold_q <= 1'b1;
    end else begin
      hold_q <= pause_req;
    end
  end

  always_ff @(negedge sclk or posedge float_now) begin
    if (float_now) begin
      oe_q <= `SFPI_OE_NONE;
    end else begin
      oe_q <= next_oe;
    end
  end

  assign lane_out = fl.lane_out;
  assign lane_oe = oe_q;

  // ========================================================================
  // system side: pins, reset pin, protection, byte handover
  logic rst_low;
  logic cs_high;

  assign cs_high = q.pin_s2[`SFPI_PIN_CS];
  // dedicated pin always counts; lane 3 only as reset with quad off and hold/reset select set
  assign rst_low = !q.pin_s2[`SFPI_PIN_RST] || (!cfg.quad_lane_enable &&
    cfg.hold_reset_select && !q.pin_s2[`SFPI_PIN_L3]);

  always_comb begin
    next_q = q;
    next_q.pin_s1 = {cs_n, reset_pin_n, lane_in[3], lane_in[2]};
    next_q.pin_s2 = q.pin_s1;
    next_q.cs_d = cs_high;
    next_q.rx_s1 = lc.rx_tgl;
    next_q.rx_s2 = q.rx_s1;
    next_q.rx_s3 = q.rx_s2;
    next_q.ack_s1 = lc.ack;
    next_q.ack_s2 = q.ack_s1;
    next_q.selected = !cs_high;
    // reset pin must stay low for the whole minimum pulse
    if (!rst_low) begin
      next_q.rst_cnt = 8'h00;
      next_q.device_reset = 1'b0;
    end else if (q.rst_cnt == RST_LAST) begin
      next_q.device_reset = 1'b1;
    end else begin
      next_q.rst_cnt = q.rst_cnt + 8'h01;
    end
    // a deselect must be seen before any selection counts
    next_q.armed = (q.armed || cs_high) && !q.device_reset;
    if (q.device_reset) begin
      next_q.frame_ok = 1'b0;
    end else if (q.cs_d && !cs_high) begin
      next_q.frame_ok = q.armed;
    end
    next_q.rx.valid = 1'b0;
    if ((q.rx_s2 != q.rx_s3) && q.frame_ok && !q.device_reset) begin
      next_q.rx = '{valid: 1'b1, first: lc.rx_instr, data: lc.rx_word};
    end
    if (tx_valid && q.tx_ready) begin
      next_q.tx_req = !q.tx_req;
      next_q.tx_data = tx_byte;
      next_q.tx_ready = 1'b0;
    end else begin
      next_q.tx_ready = (q.tx_req == q.ack_s2);
    end
    next_q.status_write_blocked = cfg.status_lock_policy &&
      !q.pin_s2[`SFPI_PIN_WP] && !cfg.quad_lane_enable;
    // guard bits freeze while locked, so software cannot shrink the region
    if (!q.status_write_blocked) begin
      next_q.guard = cfg.guard;
    end
    next_q.region_locked = q.status_write_blocked &&
      ((q.guard.block_guard != 3'h0) || q.guard.protect_complement);
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
      q.pin_s1 <= `SFPI_PIN_IDLE;
      q.pin_s2 <= `SFPI_PIN_IDLE;
      // select reads low in reset so the preset cannot stand in for a real deselect
      q.pin_s1[`SFPI_PIN_CS] <= 1'b0;
      q.pin_s2[`SFPI_PIN_CS] <= 1'b0;
      q.cs_d <= 1'b0;
      q.tx_ready <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign tx_ready = q.tx_ready;
  assign rx = q.rx;
  assign selected = q.selected;
  assign device_reset = q.device_reset;
  assign status_write_blocked = q.status_write_blocked;
  assign region_locked = q.region_locked;
  assign guard_active = q.guard;

  // ========================================================================
  // assertions
  a_deselect_float: assert property (@(posedge clk) disable iff (reset)
    cs_n |-> lane_oe == `SFPI_OE_NONE)
    else $error("lanes driven while deselected");

  a_select_seen: assert property (@(posedge clk) disable iff (reset)
    !cs_n [*3] |=> selected)
    else $error("selection not reported");

  a_arm_rx: assert property (@(posedge clk) disable iff (reset)
    rx.valid |-> q.frame_ok && q.armed)
    else $error("byte delivered without a prior select fall");

  a_reset_pulse: assert property (@(posedge clk) disable iff (reset)
    $rose(device_reset) |-> $past(q.rst_cnt) == RST_LAST && $past(rst_low, 2))
    else $error("device reset before minimum pulse");

  a_reset_release: assert property (@(posedge clk) disable iff (reset)
    !rst_low ##1 !rst_low |-> !device_reset)
    else $error("device reset held after pin release");

  a_wp_block: assert property (@(posedge clk) disable iff (reset)
    (!q.pin_s2[`SFPI_PIN_WP] && !cfg.quad_lane_enable && cfg.status_lock_policy)
    |=> status_write_blocked)
    else $error("write protect did not block status writes");

  a_quad_wp_off: assert property (@(posedge clk) disable iff (reset)
    cfg.quad_lane_enable |=> !status_write_blocked && !region_locked [*1])
    else $error("write protect active with quad lanes");

  a_quad_gate: assert property (@(posedge sclk) disable iff (cs_n)
    !lc.qe_s2 |-> w_eff != SFPI_QUAD && (lane_oe != `SFPI_OE_QUAD))
    else $error("quad width used without quad lane enable");

  a_hold_freeze: assert property (@(posedge sclk) disable iff (cs_n)
    hold_q |=> $stable(r.bit_cnt) && $stable(r.shift))
    else $error("capture advanced during pause");

  a_hold_float: assert property (@(posedge clk) disable iff (reset)
    (hold_q && !cs_n) |-> lane_oe == `SFPI_OE_NONE)
    else $error("lanes driven during pause");

  a_pause_quad: assert property (@(posedge sclk) disable iff (cs_n)
    lc.qe_s2 [*2] |-> !hold_q)
    else $error("pause active with quad lanes");

  a_tx_accept: assert property (@(posedge clk) disable iff (reset)
    tx_valid && tx_ready |=> !tx_ready ##1 !tx_ready)
    else $error("read byte handshake not held");

  c_instr_byte: cover property (@(posedge clk) disable iff (reset) rx.valid && rx.first);
  c_pin_reset: cover property (@(posedge clk) disable iff (reset) $rose(device_reset));
  c_pause: cover property (@(posedge sclk) disable iff (cs_n) hold_q ##1 !hold_q);
  c_quad_read: cover property (@(posedge clk) disable iff (reset) lane_oe == `SFPI_OE_QUAD);

endmodule : sfpi_top

// ### bench/sfpi_host_model.sv
`timescale 1ns/1ps
// ==========================================================================
// host controller: makes the serial clock only inside frames
module sfpi_host_model
  import sfpi_pkg::*;
(
  output logic sclk,
  output logic cs_n,
  output logic [1:0] lane_drv,
  input wire logic [3:0] lane_out,
  input wire logic [3:0] lane_oe
);
  logic [31:0] rd;
  int nbits;

  // powered up already selected, so a select fall is still owed
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    lane_drv = 2'h0;
    rd = 32'h0;
    nbits = 0;
  end

  // ========================================================================
  // one frame: n clocks, first nwr of them write wbits msb first on lane 0
  task automatic frame(input logic mode3, input logic [31:0] wbits, input int nwr,
                       input int n);
    sclk = mode3;
    #3;
    cs_n = 1'b0;
    rd = 32'h0;
    nbits = 0;
    for (int i = 0; i < n; i++) begin
      if (i > 0 || mode3) sclk = 1'b0;
      // a released lane toggles so a stale value never looks valid
      lane_drv = (i < nwr) ? {~lane_drv[1], wbits[31 - i]} : ~lane_drv;
      #3;
      case (lane_oe)
        4'h2: begin
          rd = {rd[30:0], lane_out[1]};
          nbits += 1;
        end
        4'h3: begin
          rd = {rd[29:0], lane_out[1:0]};
          nbits += 2;
        end
        4'hf: begin
          rd = {rd[27:0], lane_out};
          nbits += 4;
        end
        default: ;
      endcase
      sclk = 1'b1;
      #3;
    end
    sclk = mode3;
    #3;
    cs_n = 1'b1;
  endtask : frame
endmodule : sfpi_host_model

// ### bench/sfpi_top_tb_top.sv
`timescale 1ns/1ps
module sfpi_top_tb_top
  import sfpi_pkg::*;
;
  logic clk, reset, reset_pin_n, wp_n, pin3, tx_valid, tx_ready;
  logic selected, device_reset, status_write_blocked, region_locked, sclk, cs_n;
  logic [1:0] host_drv;
  logic [3:0] lane_in, lane_out, lane_oe;
  logic [7:0] tx_byte;
  sfpi_cfg_t cfg;
  sfpi_rx_t rx;
  sfpi_guard_t guard_active;
  logic [8:0] rxq[$];
  int miscompares, tests_run;

  // ========================================================================
  // pins: whoever enables a lane wins, else host or pin level
  assign lane_in = (lane_oe & lane_out) | (~lane_oe & {pin3, wp_n, host_drv});

  sfpi_top u_dut (.clk(clk), .reset(reset), .sclk(sclk), .cs_n(cs_n), .lane_in(lane_in),
    .lane_out(lane_out), .lane_oe(lane_oe), .reset_pin_n(reset_pin_n), .cfg(cfg),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .rx(rx),
    .selected(selected), .device_reset(device_reset),
    .status_write_blocked(status_write_blocked), .region_locked(region_locked),
    .guard_active(guard_active));

  sfpi_host_model u_host (.sclk(sclk), .cs_n(cs_n), .lane_drv(host_drv),
    .lane_out(lane_out), .lane_oe(lane_oe));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  always @(posedge clk) begin
    if (rx.valid === 1'b1) rxq.push_back({rx.first, rx.data});
  end

  // ========================================================================
  // tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc

  task automatic offer(input logic [7:0] b);
    @(negedge clk);
    tx_valid = 1'b1;
    tx_byte = b;
    for (int i = 0; i < 50 && tx_ready !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    tx_valid = 1'b0;
  endtask : offer

  // config crosses on the serial clock, so a short frame carries it over
  task automatic tx_setup(input sfpi_width_t w, input logic qe, input logic [7:0] b);
    @(negedge clk);
    cfg.lane_width = w;
    cfg.quad_lane_enable = qe;
    u_host.frame(1'b0, 32'h0, 0, 4);
    cyc(4);
    offer(b);
  endtask : tx_setup

  task automatic tx_case(input sfpi_width_t w, input logic qe, input logic [7:0] b);
    tx_setup(w, qe, b);
    u_host.frame(1'b0, 32'h0, 0, 24);
    cyc(4);
  endtask : tx_case

  task automatic pulse(input logic ded, input int n, input logic exp);
    @(negedge clk);
    if (ded) reset_pin_n = 1'b0;
    else pin3 = 1'b0;
    cyc(n);
    chk(device_reset, exp);
    reset_pin_n = 1'b1;
    pin3 = 1'b1;
    cyc(6);
    chk(device_reset, 1'b0);
  endtask : pulse

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : give_verdict

  initial begin
    #80000;
    miscompares++;
    give_verdict();
  end

  // ========================================================================
  // tests
  initial begin
    miscompares = 0;
    tests_run = 0;
    reset = 1'b1;
    reset_pin_n = 1'b1;
    wp_n = 1'b1;
    pin3 = 1'b1;
    tx_valid = 1'b0;
    tx_byte = 8'h00;
    cfg = '0;
    cfg.lane_width = SFPI_SINGLE;
    cyc(6);
    reset = 1'b0;
    u_host.frame(1'b0, 32'ha500_0000, 8, 8);
    cyc(10);
    chk(rxq.size(), 0);
    chk(lane_oe, 4'h0);
    chk(selected, 1'b0);
    u_host.frame(1'b0, 32'ha5c3_0000, 16, 16);
    cyc(10);
    chk(rxq.size(), 2);
    chk(rxq[0], 9'h1a5);
    chk(rxq[1], 9'h0c3);
    rxq.delete();
    u_host.frame(1'b1, 32'h3c00_0000, 8, 8);
    cyc(10);
    chk(rxq.size(), 1);
    chk(rxq[0], 9'h13c);
    tx_case(SFPI_SINGLE, 1'b0, 8'hb6);
    chk({u_host.nbits[7:0], u_host.rd[7:0]}, 16'h08b6);
    tx_case(SFPI_DUAL, 1'b0, 8'h4d);
    chk({u_host.nbits[7:0], u_host.rd[7:0]}, 16'h084d);
    pin3 = 1'b0;
    tx_case(SFPI_QUAD, 1'b1, 8'he2);
    chk({u_host.nbits[7:0], u_host.rd[7:0]}, 16'h08e2);
    pin3 = 1'b1;
    tx_case(SFPI_QUAD, 1'b0, 8'h71);
    chk({u_host.nbits[7:0], u_host.rd[7:0]}, 16'h0871);
    tx_setup(SFPI_SINGLE, 1'b0, 8'h69);
    fork
      u_host.frame(1'b0, 32'h0, 0, 28);
      begin
        cyc(4);
        pin3 = 1'b0;
        cyc(2);
        chk(lane_oe, 4'h0);
        cyc(3);
        pin3 = 1'b1;
      end
    join
    cyc(4);
    chk({u_host.nbits[7:0], u_host.rd[7:0]}, 16'h0869);
    cfg.status_lock_policy = 1'b1;
    cfg.guard = 6'h02;
    wp_n = 1'b0;
    cyc(6);
    chk({status_write_blocked, region_locked}, 2'h3);
    cfg.guard = 6'h00;
    cyc(6);
    chk(guard_active, 6'h02);
    wp_n = 1'b1;
    cyc(6);
    chk({status_write_blocked, guard_active}, 7'h00);
    cfg.quad_lane_enable = 1'b1;
    wp_n = 1'b0;
    cyc(6);
    chk(status_write_blocked, 1'b0);
    wp_n = 1'b1;
    cfg.quad_lane_enable = 1'b0;
    pulse(1'b1, 100, 1'b0);
    pulse(1'b1, 135, 1'b1);
    cfg.quad_lane_enable = 1'b1;
    pulse(1'b1, 135, 1'b1);
    pulse(1'b0, 135, 1'b0);
    cfg.quad_lane_enable = 1'b0;
    cfg.hold_reset_select = 1'b1;
    pulse(1'b0, 135, 1'b1);
    cfg.hold_reset_select = 1'b0;
    pulse(1'b0, 135, 1'b0);
    give_verdict();
  end
endmodule : sfpi_top_tb_top
